// File: design/ith_defines.svh
// Constants for the interrupt type handling block.
`ifndef ITH_DEFINES_SVH
`define ITH_DEFINES_SVH
`define ITH_NUM_CPUS 2
`define ITH_NUM_SPIS 32
`define ITH_NUM_LPIS 8
`define ITH_PPI_BASE 14'h0010
`define ITH_SPI_BASE 14'h0020
`define ITH_LPI_BASE 14'h2000
`define ITH_SPI_SYNC 32'hFFFFFFFF
`define ITH_SPI_INV 32'h00000000
`define ITH_PPI_SYNC 16'hFFFF
`define ITH_PPI_INV 16'h0000
`define ITH_PPI_IDLE 16'hFFFF
`define ITH_PPI_TRIG_RST 16'h0000
`define ITH_PPI_POL_RST 16'h0000
`define ITH_EN_RST 32'hFFFFFFFF
`define ITH_OFF_SPI_TRIG 16'h0000
`define ITH_OFF_SPI_ANY 16'h0004
`define ITH_OFF_SPI_CORE 16'h0008
`define ITH_OFF_SPI_PEND 16'h000C
`define ITH_OFF_SPI_ACT 16'h0010
`define ITH_OFF_SET_NS 16'h0040
`define ITH_OFF_SET_S 16'h0048
`define ITH_OFF_SET_LPI 16'h0050
`define ITH_OFF_LPI_STAT 16'h0054
`define ITH_CORE_PAGE 8'h01
`define ITH_LPI_CORE_BIT 16
`define ITH_LPI_GROUP_BIT 31
`endif

// File: design/ith_interrupt_type_handling.sv
// Interrupt type handling: wire conditioning, pending and active state, and selection.
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`include "ith_defines.svh"
module ith_interrupt_type_handling
    import ith_pkg::*;
#(
    parameter bit HAS_TRANSLATION = 1'b1
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [16:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [`ITH_NUM_SPIS-1:0] spi_in,
    input wire logic [`ITH_NUM_CPUS-1:0][15:0] ppi_in,
    input wire logic [`ITH_NUM_CPUS-1:0] cpu_sgi_valid,
    input wire logic [`ITH_NUM_CPUS-1:0][3:0] cpu_sgi_id,
    input wire logic [`ITH_NUM_CPUS-1:0][`ITH_NUM_CPUS-1:0] cpu_sgi_targets,
    input wire logic [`ITH_NUM_CPUS-1:0] cpu_ack_valid,
    input wire logic [`ITH_NUM_CPUS-1:0][13:0] cpu_ack_id,
    input wire logic [`ITH_NUM_CPUS-1:0] cpu_eoi_valid,
    input wire logic [`ITH_NUM_CPUS-1:0][13:0] cpu_eoi_id,
    output logic [`ITH_NUM_CPUS-1:0] cpu_irq_valid,
    output logic [`ITH_NUM_CPUS-1:0][13:0] cpu_irq_id
);
    localparam int NC = `ITH_NUM_CPUS;
    localparam logic [31:0] SPI_SYNC = `ITH_SPI_SYNC;
    localparam logic [31:0] SPI_INV = `ITH_SPI_INV;
    localparam logic [15:0] PPI_SYNC = `ITH_PPI_SYNC;
    localparam logic [15:0] PPI_INV = `ITH_PPI_INV;
    localparam logic [15:0] PPI_IDLE = `ITH_PPI_IDLE;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Classifies an identifier into its interrupt type.
    function automatic ith_class_type id_class(input ith_id_type id);
        if (id < `ITH_SPI_BASE)
            return ITH_CLS_PRIV;
        else if (id < `ITH_SPI_BASE + 14'(`ITH_NUM_SPIS))
            return ITH_CLS_SPI;
        else if (id >= `ITH_LPI_BASE && id < `ITH_LPI_BASE + 14'(`ITH_NUM_LPIS))
            return ITH_CLS_LPI;
        else
            return ITH_CLS_NONE;
    endfunction : id_class

    // Returns a found flag and the index of the lowest set bit.
    function automatic logic [5:0] lowest_set(input logic [31:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 31; i >= 0; i--)
            if (v[i])
                r = {1'b1, 5'(i)};
        return r;
    endfunction : lowest_set

    // Merges write data into a register under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
        input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (dat & m);
    endfunction : merge

    // ----------------------------------------------------------------
    // Input conditioning and collator
    // ----------------------------------------------------------------
    logic [31:0] spi_s1, spi_s2, spi_cond, col_prev, col_level, col_rise;
    logic [NC-1:0][15:0] ppi_s1, ppi_s2, ppi_cond, ppi_prev, ppi_rise;
    genvar gc;
    // Two-stage synchronizers on every wire; the build masks pick, per wire,
    // the synchronized or the raw level. The private chain resets to the idle
    // level of an active-low input, so reset does not fake pending interrupts.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            spi_s1 <= 32'h00000000;
            spi_s2 <= 32'h00000000;
            ppi_s1 <= {NC{PPI_IDLE}};
            ppi_s2 <= {NC{PPI_IDLE}};
        end
        else
        begin
            spi_s1 <= spi_in;
            spi_s2 <= spi_s1;
            ppi_s1 <= ppi_in;
            ppi_s2 <= ppi_s1;
        end
    end
    assign spi_cond = ((spi_s2 & SPI_SYNC) | (spi_in & ~SPI_SYNC)) ^ SPI_INV;
    for (gc = 0; gc < NC; gc++)
    begin : g_core
        assign ppi_cond[gc] = ((ppi_s2[gc] & PPI_SYNC) | (ppi_in[gc] & ~PPI_SYNC)) ^ PPI_INV;
        assign ppi_rise[gc] = ppi_cond[gc] & ~ppi_prev[gc];
    end

    // The collator turns wire levels into level and rise messages one stage
    // ahead of the distributor state, so that state can sit in a gated domain.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            col_prev <= 32'h00000000;
            col_level <= 32'h00000000;
            col_rise <= 32'h00000000;
            ppi_prev <= {NC{PPI_IDLE ^ PPI_INV}};
        end
        else
        begin
            col_prev <= spi_cond;
            col_level <= spi_cond;
            col_rise <= spi_cond & ~col_prev;
            ppi_prev <= ppi_cond;
        end
    end

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic wr, rd, page1, core_hit, spi_set_wr, spi_id_ok, lpi_wr, lpi_id_ok;
    logic [15:0] off;
    logic [0:0] core_sel, lpi_core;
    logic [31:0] spi_trig, spi_any, spi_core, spi_lat, spi_act, spi_pend, spi_sw_set;
    logic [31:0] spi_clr, spi_eoi, next_rdata;
    logic [NC-1:0][15:0] ppi_trig, ppi_pol, sgi_lat, ppi_lat, sgi_set;
    logic [NC-1:0][31:0] en, priv_act, priv_pend, priv_cand, priv_clr, priv_eoi, spi_cand;
    logic [NC-1:0][7:0] lpi_pend, lpi_set, lpi_clr;
    logic [NC-1:0] next_irq_valid;
    logic [NC-1:0][13:0] next_irq_id;

    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    assign page1 = wb_adr_i[16];
    assign off = wb_adr_i[15:0];
    assign core_sel = off[4];
    assign core_hit = !page1 && off[15:8] == `ITH_CORE_PAGE && off[7:5] == 3'h0;
    assign spi_set_wr = wr && !page1 && (off == `ITH_OFF_SET_NS || off == `ITH_OFF_SET_S);
    assign spi_id_ok = id_class(wb_dat_i[13:0]) == ITH_CLS_SPI;
    assign spi_sw_set = (spi_set_wr && spi_id_ok) ? 32'h00000001 << wb_dat_i[4:0] : '0;
    // The translation register shares its offset with the non-secure set
    // register, only the page bit differs, so remapping a page suffices.
    assign lpi_wr = wr && (HAS_TRANSLATION ? (page1 && off == `ITH_OFF_SET_NS)
                                           : (!page1 && off == `ITH_OFF_SET_LPI));
    assign lpi_id_ok = id_class(wb_dat_i[13:0]) == ITH_CLS_LPI;
    assign lpi_core = wb_dat_i[`ITH_LPI_CORE_BIT];

    // Single-wait acknowledge; ack drops in the cycle after it was given.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end

    // Read data mux; unmapped and write-only addresses read as zero.
    always_comb
    begin
        next_rdata = 32'h00000000;
        if (core_hit)
        begin
            unique case (off[3:2])
                2'h0: next_rdata = {16'h0000, ppi_trig[core_sel]};
                2'h1: next_rdata = {16'h0000, ppi_pol[core_sel]};
                2'h2: next_rdata = en[core_sel];
                2'h3: next_rdata = priv_pend[core_sel];
            endcase
        end
        else if (!page1)
        begin
            case (off)
                `ITH_OFF_SPI_TRIG: next_rdata = spi_trig;
                `ITH_OFF_SPI_ANY: next_rdata = spi_any;
                `ITH_OFF_SPI_CORE: next_rdata = spi_core;
                `ITH_OFF_SPI_PEND: next_rdata = spi_pend;
                `ITH_OFF_SPI_ACT: next_rdata = spi_act;
                `ITH_OFF_LPI_STAT: next_rdata = {1'b1, 15'h0000, lpi_pend[1], lpi_pend[0]};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            wb_dat_o <= 32'h00000000;
        else if (rd)
            wb_dat_o <= next_rdata;
    end

    // Configuration registers written by software steer triggering and routing.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            spi_trig <= 32'h00000000;
            spi_any <= 32'h00000000;
            spi_core <= 32'h00000000;
            for (int c = 0; c < NC; c++)
            begin
                ppi_trig[c] <= `ITH_PPI_TRIG_RST;
                ppi_pol[c] <= `ITH_PPI_POL_RST;
                en[c] <= `ITH_EN_RST;
            end
        end
        else if (wr && core_hit)
        begin
            unique case (off[3:2])
                2'h0: ppi_trig[core_sel] <= 16'(merge(32'(ppi_trig[core_sel]), wb_dat_i, wb_sel_i));
                2'h1: ppi_pol[core_sel] <= 16'(merge(32'(ppi_pol[core_sel]), wb_dat_i, wb_sel_i));
                2'h2: en[core_sel] <= merge(en[core_sel], wb_dat_i, wb_sel_i);
                2'h3: en[core_sel] <= en[core_sel];
            endcase
        end
        else if (wr && !page1)
        begin
            if (off == `ITH_OFF_SPI_TRIG)
                spi_trig <= merge(spi_trig, wb_dat_i, wb_sel_i);
            if (off == `ITH_OFF_SPI_ANY)
                spi_any <= merge(spi_any, wb_dat_i, wb_sel_i);
            if (off == `ITH_OFF_SPI_CORE)
                spi_core <= merge(spi_core, wb_dat_i, wb_sel_i);
        end
    end

    // ----------------------------------------------------------------
    // Pending, candidates and activation
    // ----------------------------------------------------------------
    // Level-mode wires pend while asserted; edge-mode and written events latch.
    assign spi_pend = spi_lat | (col_level & ~spi_trig);
    always_comb
    begin
        sgi_set = '0;
        lpi_set = '0;
        for (int s = 0; s < NC; s++)
            for (int c = 0; c < NC; c++)
                if (cpu_sgi_valid[s] && cpu_sgi_targets[s][c])
                    sgi_set[c][cpu_sgi_id[s]] = 1'b1;
        if (lpi_wr && lpi_id_ok)
            lpi_set[lpi_core][wb_dat_i[2:0]] = 1'b1;
        for (int c = 0; c < NC; c++)
        begin
            // Polarity applies to level mode; edge mode looks for a rising wire.
            priv_pend[c] = {ppi_lat[c] | (~(ppi_cond[c] ^ ppi_pol[c]) & ~ppi_trig[c]),
                            sgi_lat[c]};
            priv_cand[c] = priv_pend[c] & en[c] & ~priv_act[c];
            spi_cand[c] = spi_pend & ~spi_act & (spi_any | (c[0] ? spi_core : ~spi_core));
        end
    end

    // Activation: a shared one taken by a lower core in the same cycle is refused
    // to the others, so at most one core ever holds it active.
    always_comb
    begin
        spi_clr = '0;
        spi_eoi = '0;
        priv_clr = '0;
        priv_eoi = '0;
        lpi_clr = '0;
        for (int c = 0; c < NC; c++)
        begin
            if (cpu_ack_valid[c])
            begin
                if (id_class(cpu_ack_id[c]) == ITH_CLS_PRIV && priv_cand[c][cpu_ack_id[c][4:0]])
                    priv_clr[c][cpu_ack_id[c][4:0]] = 1'b1;
                else if (id_class(cpu_ack_id[c]) == ITH_CLS_SPI && spi_cand[c][cpu_ack_id[c][4:0]]
                         && !spi_clr[cpu_ack_id[c][4:0]])
                    spi_clr[cpu_ack_id[c][4:0]] = 1'b1;
                else if (id_class(cpu_ack_id[c]) == ITH_CLS_LPI && lpi_pend[c][cpu_ack_id[c][2:0]])
                    lpi_clr[c][cpu_ack_id[c][2:0]] = 1'b1;
            end
            if (cpu_eoi_valid[c] && id_class(cpu_eoi_id[c]) == ITH_CLS_PRIV)
                priv_eoi[c][cpu_eoi_id[c][4:0]] = 1'b1;
            if (cpu_eoi_valid[c] && id_class(cpu_eoi_id[c]) == ITH_CLS_SPI)
                spi_eoi[cpu_eoi_id[c][4:0]] = 1'b1;
        end
    end

    // Sticky state: a new event in the cycle of its clear is kept.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            spi_lat <= 32'h00000000;
            spi_act <= 32'h00000000;
            sgi_lat <= '0;
            ppi_lat <= '0;
            priv_act <= '0;
            lpi_pend <= '0;
        end
        else
        begin
            spi_lat <= (spi_lat & ~spi_clr) | (col_rise & spi_trig) | spi_sw_set;
            spi_act <= (spi_act & ~spi_eoi) | spi_clr;
            for (int c = 0; c < NC; c++)
            begin
                sgi_lat[c] <= (sgi_lat[c] & ~priv_clr[c][15:0]) | sgi_set[c];
                ppi_lat[c] <= (ppi_lat[c] & ~priv_clr[c][31:16]) | (ppi_rise[c] & ppi_trig[c]);
                priv_act[c] <= (priv_act[c] & ~priv_eoi[c]) | priv_clr[c];
                lpi_pend[c] <= (lpi_pend[c] & ~lpi_clr[c]) | lpi_set[c];
            end
        end
    end

    // ----------------------------------------------------------------
    // Selection toward each core
    // ----------------------------------------------------------------
    // Lowest identifier wins; private before shared before locality.
    always_comb
    begin
        for (int c = 0; c < NC; c++)
        begin
            next_irq_valid[c] = 1'b1;
            if (lowest_set(priv_cand[c]) >= 6'h20)
                next_irq_id[c] = 14'(lowest_set(priv_cand[c]) - 6'h20);
            else if (lowest_set(spi_cand[c]) >= 6'h20)
                next_irq_id[c] = `ITH_SPI_BASE + 14'(lowest_set(spi_cand[c]) - 6'h20);
            else if (lowest_set({24'h000000, lpi_pend[c]}) >= 6'h20)
                next_irq_id[c] = `ITH_LPI_BASE + 14'(lowest_set({24'h000000, lpi_pend[c]}) - 6'h20);
            else
            begin
                next_irq_valid[c] = 1'b0;
                next_irq_id[c] = 14'h0000;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cpu_irq_valid <= '0;
            cpu_irq_id <= '0;
        end
        else
        begin
            cpu_irq_valid <= next_irq_valid;
            cpu_irq_id <= next_irq_id;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_sgi_edge_set: assert property (
        cpu_sgi_valid[0] && cpu_sgi_targets[0][1] |=> sgi_lat[1][$past(cpu_sgi_id[0])])
        else $error("inter-core request not recorded at target");
    chk_sgi_id_range: assert property (
        next_irq_valid[0] && next_irq_id[0] < `ITH_PPI_BASE |-> sgi_lat[0][next_irq_id[0][3:0]])
        else $error("inter-core identifier selected without record");
    chk_core_isolated: assert property (
        !cpu_ack_valid[1] && !cpu_eoi_valid[1] |=> $stable(priv_act[1]))
        else $error("core one active state changed by another core");
    chk_ppi_own_core: assert property (
        $rose(ppi_lat[1][0]) |-> $past(ppi_rise[1][0] && ppi_trig[1][0]))
        else $error("private pending set without own wire edge");
    chk_ppi_reset_dflt: assert property (
        $past(sys_rst) |-> ppi_trig[0] == `ITH_PPI_TRIG_RST && ppi_pol[0] == `ITH_PPI_POL_RST)
        else $error("private trigger defaults wrong after reset");
    chk_spi_one_owner: assert property (
        spi_act[0] |=> !(cpu_irq_valid[0] && cpu_irq_id[0] == `ITH_SPI_BASE)
            && !(cpu_irq_valid[1] && cpu_irq_id[1] == `ITH_SPI_BASE))
        else $error("active shared interrupt still offered");
    chk_spi_set_write: assert property (
        spi_set_wr && spi_id_ok |=> spi_lat[$past(wb_dat_i[4:0])])
        else $error("valid set-pending write lost");
    chk_spi_level_path: assert property (
        $rose(spi_in[0]) && !spi_trig[0] ##1 (spi_in[0] && !spi_trig[0])[*3] |-> spi_pend[0])
        else $error("level shared wire not pending after collator");
    chk_lpi_target: assert property (
        lpi_wr && lpi_id_ok |=> lpi_pend[$past(lpi_core)][$past(wb_dat_i[2:0])])
        else $error("locality write did not pend at its core");
    chk_spi_activate: assert property (
        cpu_ack_valid[0] && cpu_ack_id[0] == `ITH_SPI_BASE && spi_cand[0][0] |=> spi_act[0])
        else $error("shared activation not taken");
    cov_sgi_cross: cover property (cpu_sgi_valid[0] && cpu_sgi_targets[0][1]);
    cov_spi_race: cover property (cpu_ack_valid[0] && cpu_ack_valid[1]
        && cpu_ack_id[0] == cpu_ack_id[1] && spi_clr != 32'h00000000);
    cov_lpi_raise: cover property (lpi_wr && lpi_id_ok);
    cov_ppi_edge: cover property (ppi_rise[1] != 16'h0000 && ppi_trig[1] != 16'h0000);
endmodule : ith_interrupt_type_handling

// File: design/ith_pkg.sv
// Types shared by the interrupt type handling block.
package ith_pkg;
    typedef logic [13:0] ith_id_type;
    typedef enum logic [1:0] {
        ITH_CLS_PRIV = 2'h0,
        ITH_CLS_SPI = 2'h1,
        ITH_CLS_LPI = 2'h2,
        ITH_CLS_NONE = 2'h3
    } ith_class_type;
endpackage : ith_pkg

// File: sim/interrupt_type_handling_test.sv
// Self-checking bench for the interrupt type handling block.
`timescale 1ns/100ps
module interrupt_type_handling_test;
    logic clk, sys_rst, cyc, stb, we, ack;
    logic [16:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q, spi_in;
    logic [1:0][15:0] ppi_in;
    logic [1:0] sgi_v, ack_v, irq_v, take_en;
    logic [1:0][3:0] sgi_id;
    logic [1:0][1:0] sgi_tgt;
    logic [1:0][13:0] ack_id, irq_id;
    int fail_count = 0;
    int tests_run = 0;
    ith_interrupt_type_handling uut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .spi_in(spi_in), .ppi_in(ppi_in),
        .cpu_sgi_valid(sgi_v), .cpu_sgi_id(sgi_id), .cpu_sgi_targets(sgi_tgt),
        .cpu_ack_valid(ack_v), .cpu_ack_id(ack_id), .cpu_eoi_valid(2'h0),
        .cpu_eoi_id(28'h0000000), .cpu_irq_valid(irq_v), .cpu_irq_id(irq_id));
    ith_core_model core (.clk(clk), .sys_rst(sys_rst), .take_en(take_en),
        .cpu_irq_valid(irq_v), .cpu_irq_id(irq_id), .cpu_ack_valid(ack_v), .cpu_ack_id(ack_id));
    // Free-running 200 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    // Classic cycle: hold the request until ack is sampled, then idle one cycle.
    task automatic wb(input logic w, input logic [16:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                fail_count++;
                end_sim();
            end
            @(posedge clk);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    // Wait, bounded, until the offer line of core c reaches level v.
    task automatic wait_irq(input int c, input logic v);
        int n;
        n = 0;
        @(posedge clk);
        while (irq_v[c] !== v)
        begin
            n++;
            if (n > 12)
            begin
                fail_count++;
                end_sim();
            end
            @(posedge clk);
        end
    endtask : wait_irq
    task automatic software_generated_interrupt(input logic [3:0] id, input logic [1:0] tgt);
        sgi_v[0] <= 1'b1;
        sgi_id[0] <= id;
        sgi_tgt[0] <= tgt;
        @(posedge clk);
        sgi_v[0] <= 1'b0;
    endtask : software_generated_interrupt
    task automatic s_sgi;
        software_generated_interrupt(4'h5, 2'h2);
        wait_irq(1, 1'b1);
        chk(irq_id[1], 32'h5);
        chk(irq_v[0], 32'h0);
        take_en <= 2'h2;
        wait_irq(1, 1'b0);
        take_en <= 2'h0;
        software_generated_interrupt(4'hF, 2'h3);
        wait_irq(0, 1'b1);
        chk(irq_id[0], 32'hF);
        take_en <= 2'h1;
        wait_irq(0, 1'b0);
        chk(irq_v[1], 32'h1);
        chk(irq_id[1], 32'hF);
        take_en <= 2'h2;
        wait_irq(1, 1'b0);
        take_en <= 2'h0;
    endtask : s_sgi
    task automatic s_ppi;
        ppi_in[0][3] <= 1'b0;
        wait_irq(0, 1'b1);
        chk(irq_id[0], 32'h13);
        chk(irq_v[1], 32'h0);
        ppi_in[0][3] <= 1'b1;
        wait_irq(0, 1'b0);
        wb(1'b1, 17'h00104, 32'h8);
        wait_irq(0, 1'b1);
        chk(irq_id[0], 32'h13);
        wb(1'b1, 17'h00104, 32'h0);
        wait_irq(0, 1'b0);
        wb(1'b1, 17'h00110, 32'h1);
        ppi_in[1][0] <= 1'b0;
        repeat (4) @(posedge clk);
        chk(irq_v[1], 32'h0);
        ppi_in[1][0] <= 1'b1;
        wait_irq(1, 1'b1);
        chk(irq_id[1], 32'h10);
        chk(irq_v[0], 32'h0);
        take_en <= 2'h2;
        wait_irq(1, 1'b0);
        take_en <= 2'h0;
    endtask : s_ppi
    task automatic s_spi;
        wb(1'b1, 17'h00040, 32'h22);
        wb(1'b1, 17'h00048, 32'h21);
        wb(1'b1, 17'h00040, 32'h40);
        wb(1'b0, 17'h0000C, 32'h0);
        chk(q, 32'h6);
        wait_irq(0, 1'b1);
        chk(irq_id[0], 32'h21);
        chk(irq_v[1], 32'h0);
        wb(1'b0, 17'h000FC, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, 17'h00008, 32'h4);
        wb(1'b1, 17'h00004, 32'h2);
        wait_irq(1, 1'b1);
        chk(irq_id[1], 32'h21);
        take_en <= 2'h3;
        wait_irq(0, 1'b0);
        take_en <= 2'h0;
        chk(irq_id[1], 32'h22);
        wb(1'b0, 17'h00010, 32'h0);
        chk(q, 32'h2);
        wb(1'b0, 17'h0000C, 32'h0);
        chk(q, 32'h4);
        take_en <= 2'h2;
        wait_irq(1, 1'b0);
        take_en <= 2'h0;
    endtask : s_spi
    // Shared wires: a level input stays pending after activation, an edge input does not.
    task automatic s_wire;
        spi_in[0] <= 1'b1;
        wait_irq(0, 1'b1);
        chk(irq_id[0], 32'h20);
        take_en <= 2'h1;
        wait_irq(0, 1'b0);
        take_en <= 2'h0;
        wb(1'b0, 17'h0000C, 32'h0);
        chk(q, 32'h1);
        spi_in[0] <= 1'b0;
        wb(1'b1, 17'h00000, 32'h8);
        spi_in[3] <= 1'b1;
        @(posedge clk);
        spi_in[3] <= 1'b0;
        wait_irq(0, 1'b1);
        chk(irq_id[0], 32'h23);
        take_en <= 2'h1;
        wait_irq(0, 1'b0);
        take_en <= 2'h0;
        wb(1'b0, 17'h0000C, 32'h0);
        chk(q, 32'h0);
    endtask : s_wire
    task automatic s_lpi;
        wb(1'b0, 17'h00054, 32'h0);
        chk(q, 32'h80000000);
        wb(1'b1, 17'h10040, 32'h00012001);
        wb(1'b0, 17'h00054, 32'h0);
        chk(q, 32'h80000200);
        wait_irq(1, 1'b1);
        chk(irq_id[1], 32'h2001);
        take_en <= 2'h2;
        wait_irq(1, 1'b0);
        take_en <= 2'h0;
    endtask : s_lpi
    // Main sequence: reset for five cycles, then each scenario in turn.
    initial
    begin
        sys_rst = 1'b1;
        {cyc, stb, we, adr, wdat, spi_in, sgi_v, sgi_id, sgi_tgt, take_en} = '0;
        sel = 4'hF;
        ppi_in = '1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk({ack, irq_v}, 32'h0);
        s_sgi();
        s_ppi();
        s_spi();
        s_wire();
        s_lpi();
        end_sim();
    end
endmodule : interrupt_type_handling_test

// File: sim/ith_core_model.sv
// Processor core model that takes each offered interrupt when enabled.
`timescale 1ns/100ps
module ith_core_model
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] take_en,
    input wire logic [1:0] cpu_irq_valid,
    input wire logic [1:0][13:0] cpu_irq_id,
    output logic [1:0] cpu_ack_valid,
    output logic [1:0][13:0] cpu_ack_id
);
    logic [1:0][1:0] hold;
    // One acknowledge per offer; the hold-off covers the two-cycle lag of the offer.
    always_ff @(posedge clk)
    begin
        for (int c = 0; c < 2; c++)
        begin
            cpu_ack_valid[c] <= 1'b0;
            cpu_ack_id[c] <= ~cpu_ack_id[c]; // Idle id toggles so it is never trusted.
            if (sys_rst)
                hold[c] <= 2'h0;
            else if (hold[c] != 2'h0)
                hold[c] <= hold[c] - 2'h1;
            else if (take_en[c] && cpu_irq_valid[c])
            begin
                cpu_ack_valid[c] <= 1'b1;
                cpu_ack_id[c] <= cpu_irq_id[c];
                hold[c] <= 2'h3;
            end
        end
    end
endmodule : ith_core_model
